// ==== hw/irq_rst_defines.svh ====
`ifndef IRQ_RST_DEFINES_SVH
`define IRQ_RST_DEFINES_SVH

// Register byte offsets on the bus.
`define OFS_PIN_CTRL 4'h0
`define OFS_RST_STATUS 4'h4
`define OFS_SYS_CFG 4'h8

// Pin control and status register fields.
`define BIT_EDGE_POL 5
`define BIT_PIN_EN 4
`define BIT_PENDING 3
`define BIT_ACK 2
`define BIT_INT_EN 1
`define BIT_LEVEL_MODE 0

// Reset status register fields.
`define BIT_POWER_ON 7
`define BIT_RST_PIN 6
`define BIT_WATCHDOG 5
`define BIT_BAD_OPCODE 4
`define BIT_BAD_ADDR 3
`define BIT_CLK_MODULE 2
`define BIT_LOW_VOLT 1

// System configuration register fields.
`define BIT_WDOG_EN 0
`define BIT_STOP_EN 1
`define BIT_BDM_EN 2
`define BIT_LVD_EN 3
`define BIT_LVD_RST_EN 4
`define BIT_LVD_STOP_EN 5

// Reset values.
`define RST_PIN_CTRL 8'h00
`define RST_STATUS_POWER_ON 8'h82
`define RST_SYS_CFG 8'h19

// Illegal address windows.
`define BAD_ADDR_LO0 16'h0880
`define BAD_ADDR_HI0 16'h17ff
`define BAD_ADDR_LO1 16'h182c
`define BAD_ADDR_HI1 16'hbfff

`endif

// ==== hw/irq_rst_pkg.sv ====
package irq_rst_pkg;

  // One byte-wide register.
  typedef logic [7:0] byte_reg_t;

  // Kind of reset seen in a cycle.
  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_LOW_VOLT,
    CAUSE_OTHER
  } reset_cause_t;

endpackage

// ==== hw/ext_irq_and_reset_status.sv ====
// What this block does
// - Bit 5 picks falling or rising polarity.
// - Rising polarity selects pull-down instead of pull-up.
// - Bit 4 enables pin function and pull.
// - Bit 3 pending set on qualifying pin event.
// - Writing 1 to bit 2 clears pending.
// - Level mode: asserted pin blocks the clear.
// - Bit 1 lets pending raise CPU request.
// - Bit 0 picks edge-only or edge plus level.
// - Two unused control bits read zero.
// - Debug forced reset clears every status bit.
// - Status write restarts watchdog, keeps contents.
// - Power-on sets power-on and low-voltage bits.
// - Low-voltage reset keeps power-on, sets low-voltage.
// - Other resets record each active source only.
// - Bit 6 marks external reset pin low.
// - Bit 5 marks watchdog; option gates it.
// - Bit 4 marks bad opcode, incl stop, background.
// - Bit 3 marks access in illegal windows.
// - Unused register locations are not illegal.
// - Bit 2 marks clock module reset request.
// - Low-voltage reset needs both enables; stop gating.

`include "irq_rst_defines.svh"

module ext_irq_and_reset_status
  import irq_rst_pkg::*;
#(
  parameter int CPU_ADDR_W = 16
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // External interrupt pin and its pull resistor.
  input wire logic irq_pin_i,
  output logic pull_enable_o,
  output logic pull_down_select_o,
  // Interrupt request to the CPU.
  output logic cpu_irq_o,
  // Reset sources.
  input wire logic reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic bad_opcode_i,
  input wire logic stop_exec_i,
  input wire logic enter_background_instruction_exec_i,
  input wire logic [CPU_ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_access_i,
  input wire logic clock_module_reset_i,
  input wire logic low_volt_trip_i,
  input wire logic stop_mode_i,
  input wire logic debug_force_reset_i,
  // Reset request and watchdog restart.
  output logic system_reset_o,
  output logic watchdog_restart_o
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------

  // The illegal windows need a 16-bit address space at least.
  if (CPU_ADDR_W < 16)
  begin : g_bad_width
    $error("CPU_ADDR_W must be 16 or more.");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------

  byte_reg_t ctrl_reg;
  logic pending_reg;
  byte_reg_t status_reg;
  byte_reg_t cfg_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic pull_en_reg;
  logic pull_dn_reg;
  logic sys_rst_reg;
  logic wd_restart_reg;
  logic bus_done;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_status;
  logic wr_cfg;
  logic asserted_now;
  logic asserted_prev;
  logic pin_event;
  logic ack_clear;
  logic src_pin;
  logic src_wdog;
  logic src_opcode;
  logic src_addr;
  logic src_clk;
  logic src_lvd;
  logic [CPU_ADDR_W-1:0] lo0;
  logic [CPU_ADDR_W-1:0] hi0;
  logic [CPU_ADDR_W-1:0] lo1;
  logic [CPU_ADDR_W-1:0] hi1;
  reset_cause_t cause;
  byte_reg_t status_next;
  byte_reg_t read_byte;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------

  // Each access waits one cycle, then completes.
  // Waitrequest rests high, so a request is never taken on the edge
  // at which it first appears.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_reg <= 1'b1;
    else if ((avs_read_i || avs_write_i) && wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  // Decodes act only in the cycle in which the access completes.
  assign bus_done = (avs_read_i || avs_write_i) && !wait_reg;
  assign wr_ok = avs_write_i && bus_done && avs_byteenable_i[0];
  assign wr_ctrl = wr_ok && (avs_address_i == `OFS_PIN_CTRL);
  assign wr_status = avs_write_i && bus_done
                     && (avs_address_i == `OFS_RST_STATUS);
  assign wr_cfg = wr_ok && (avs_address_i == `OFS_SYS_CFG);

  // Read data mux; unmapped offsets read zero.
  always_comb
  begin
    read_byte = 8'h00;
    case (avs_address_i)
      `OFS_PIN_CTRL:
      begin
        read_byte = ctrl_reg;
        read_byte[`BIT_PENDING] = pending_reg;
        read_byte[`BIT_ACK] = 1'b0;
        read_byte[7:6] = 2'b00;
      end
      `OFS_RST_STATUS: read_byte = status_reg;
      `OFS_SYS_CFG: read_byte = cfg_reg;
      default: read_byte = 8'h00;
    endcase
  end

  // Read data is captured as the wait state ends.
  // Capturing in the wait cycle lets the data stand while waitrequest
  // is low, so the master takes it at the completing edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read_i && wait_reg)
      rdata_reg <= {24'h00_0000, read_byte};
  end

  // ---------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------

  // Two-stage synchroniser and one older sample.
  // The flops rest high: an idle pin of falling polarity then shows no
  // false edge when reset is released.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= irq_pin_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Polarity turns the pin into an asserted level.
  assign asserted_now = ctrl_reg[`BIT_EDGE_POL] ? sync2_reg
                                                : !sync2_reg;
  assign asserted_prev = ctrl_reg[`BIT_EDGE_POL] ? prev_reg
                                                 : !prev_reg;

  // An event is an edge, or a held level in level mode.
  assign pin_event = ctrl_reg[`BIT_PIN_EN]
                     && ((asserted_now && !asserted_prev)
                     || (ctrl_reg[`BIT_LEVEL_MODE]
                     && asserted_now));

  // Acknowledge clears only when the level does not hold it.
  assign ack_clear = wr_ctrl && avs_writedata_i[`BIT_ACK]
                     && !(ctrl_reg[`BIT_LEVEL_MODE]
                     && asserted_now);

  // Control bits; cleared again by any system reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sys_rst_reg)
      ctrl_reg <= `RST_PIN_CTRL;
    else if (wr_ctrl)
    begin
      ctrl_reg[`BIT_EDGE_POL] <= avs_writedata_i[`BIT_EDGE_POL];
      ctrl_reg[`BIT_PIN_EN] <= avs_writedata_i[`BIT_PIN_EN];
      ctrl_reg[`BIT_INT_EN] <= avs_writedata_i[`BIT_INT_EN];
      ctrl_reg[`BIT_LEVEL_MODE] <= avs_writedata_i[`BIT_LEVEL_MODE];
    end
  end

  // Pending flag: a new event wins over a clear.
  // In level mode the held level sets the flag again each cycle, so an
  // early acknowledge cannot lose a request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sys_rst_reg)
      pending_reg <= 1'b0;
    else if (pin_event)
      pending_reg <= 1'b1;
    else if (ack_clear)
      pending_reg <= 1'b0;
  end

  // CPU request and pull resistor control.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
      pull_en_reg <= 1'b0;
      pull_dn_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= ctrl_reg[`BIT_INT_EN] && pending_reg;
      pull_en_reg <= ctrl_reg[`BIT_PIN_EN];
      pull_dn_reg <= ctrl_reg[`BIT_PIN_EN]
                     && ctrl_reg[`BIT_EDGE_POL];
    end
  end

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------

  // The limits are cast to the address width; a bus wider than 16 bits
  // is compared against the same two windows.
  assign lo0 = CPU_ADDR_W'(`BAD_ADDR_LO0);
  assign hi0 = CPU_ADDR_W'(`BAD_ADDR_HI0);
  assign lo1 = CPU_ADDR_W'(`BAD_ADDR_LO1);
  assign hi1 = CPU_ADDR_W'(`BAD_ADDR_HI1);

  // Qualify each source with its options.
  // Sources are levels sampled every cycle; one still active after the
  // pulse raises a new reset two cycles after the first.
  assign src_pin = !reset_pin_n_i;
  assign src_wdog = watchdog_timeout_i
                    && cfg_reg[`BIT_WDOG_EN];
  assign src_opcode = bad_opcode_i
                      || (stop_exec_i && !cfg_reg[`BIT_STOP_EN])
                      || (enter_background_instruction_exec_i
                      && !cfg_reg[`BIT_BDM_EN]);
  // Only the two gaps count; register areas never do.
  assign src_addr = cpu_access_i
                    && (((cpu_addr_i >= lo0) && (cpu_addr_i <= hi0))
                    || ((cpu_addr_i >= lo1)
                    && (cpu_addr_i <= hi1)));
  assign src_clk = clock_module_reset_i;
  assign src_lvd = low_volt_trip_i && cfg_reg[`BIT_LVD_EN]
                   && cfg_reg[`BIT_LVD_RST_EN]
                   && (!stop_mode_i
                   || cfg_reg[`BIT_LVD_STOP_EN]);

  // Classify the reset and build the new status value.
  // Low voltage wins when it coincides with another source.
  always_comb
  begin
    cause = CAUSE_NONE;
    status_next = status_reg;
    if (src_lvd)
      cause = CAUSE_LOW_VOLT;
    else if (src_pin || src_wdog || src_opcode || src_addr
             || src_clk || debug_force_reset_i)
      cause = CAUSE_OTHER;
    case (cause)
      CAUSE_LOW_VOLT:
      begin
        status_next = 8'h00;
        status_next[`BIT_POWER_ON] = status_reg[`BIT_POWER_ON];
        status_next[`BIT_LOW_VOLT] = 1'b1;
      end
      CAUSE_OTHER:
      begin
        // A debug force alone leaves every bit clear.
        status_next = 8'h00;
        status_next[`BIT_RST_PIN] = src_pin;
        status_next[`BIT_WATCHDOG] = src_wdog;
        status_next[`BIT_BAD_OPCODE] = src_opcode;
        status_next[`BIT_BAD_ADDR] = src_addr;
        status_next[`BIT_CLK_MODULE] = src_clk;
      end
      CAUSE_NONE: status_next = status_reg;
      default: status_next = status_reg;
    endcase
  end

  // Status is loaded on each reset; bus writes leave it alone.
  // Holding the value during the pulse keeps the recorded cause from
  // being overwritten by the reset that it triggered.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_reg <= `RST_STATUS_POWER_ON;
    else if (!sys_rst_reg)
      status_reg <= status_next;
  end

  // Reset request pulse; one cycle, then sources re-examined.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sys_rst_reg <= 1'b0;
    else
      sys_rst_reg <= !sys_rst_reg
                     && (cause != CAUSE_NONE);
  end

  // Any write to the status offset restarts the watchdog.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wd_restart_reg <= 1'b0;
    else
      wd_restart_reg <= wr_status;
  end

  // Option bits are software settable; power-on reset only.
  // Bits 7:6 have no function and always read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_reg <= `RST_SYS_CFG;
    else if (wr_cfg)
      cfg_reg <= {2'b00, avs_writedata_i[5:0]};
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Every output is a flop, so no decode glitch reaches the pins or
  // the reset tree.
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign pull_enable_o = pull_en_reg;
  assign pull_down_select_o = pull_dn_reg;
  assign cpu_irq_o = irq_reg;
  assign system_reset_o = sys_rst_reg;
  assign watchdog_restart_o = wd_restart_reg;

endmodule

// ==== tb/irq_pin_source.sv ====
module irq_pin_source
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench commands.
  input wire logic assert_i,
  input wire logic rising_i,
  input wire logic dbg_cmd_i,
  // Pin level and debug reset request.
  output logic pin_o,
  output logic dbg_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dbg_last_reg;
  // The pin rests at the inactive level, high for falling polarity.
  assign pin_o = rising_i ? assert_i : !assert_i;
  // A debug host command becomes one single-cycle reset request.
  always_ff @(posedge clk_i)
  begin
    dbg_last_reg <= rst_i ? 1'b0 : dbg_cmd_i;
    dbg_pulse_o <= !rst_i && dbg_cmd_i && !dbg_last_reg;
  end
endmodule

// ==== tb/ext_irq_and_reset_status_assertions.sv ====
module ext_irq_and_reset_status_assertions
(
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pin, pull and reset signals.
  input wire logic pull_enable_o,
  input wire logic pull_down_select_o,
  input wire logic reset_pin_n_i,
  input wire logic clock_module_reset_i,
  input wire logic system_reset_o,
  input wire logic watchdog_restart_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A completed write to the reset status offset.
  sequence s_status_wr;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
  endsequence
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest not low one cycle after request");
  property p_wait_back;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_back: assert property (p_wait_back)
    else $error("waitrequest low two cycles running");
  property p_rd_zero;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h0 |->
      avs_readdata_o[31:6] == 26'h0 && !avs_readdata_o[2];
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("pin control read shows set unused or ack bits");
  property p_restart;
    s_status_wr |=> watchdog_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("status write gave no watchdog restart");
  property p_restart_cause;
    watchdog_restart_o |->
      $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4);
  endproperty
  a_restart_cause: assert property (p_restart_cause)
    else $error("watchdog restart without status write");
  property p_pull;
    pull_down_select_o |-> pull_enable_o;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-down selected while pull is off");
  property p_pin_rst;
    $fell(reset_pin_n_i) |-> ##[1:2] system_reset_o;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin low gave no reset");
  property p_clk_rst;
    $rose(clock_module_reset_i) |-> ##[1:2] system_reset_o;
  endproperty
  a_clk_rst: assert property (p_clk_rst)
    else $error("clock module request gave no reset");
  property p_rst_pulse;
    system_reset_o |=> !system_reset_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset request longer than one cycle");
endmodule
bind ext_irq_and_reset_status ext_irq_and_reset_status_assertions
  ext_irq_and_reset_status_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pull_enable_o(pull_enable_o),
  .pull_down_select_o(pull_down_select_o), .reset_pin_n_i(reset_pin_n_i),
  .clock_module_reset_i(clock_module_reset_i),
  .system_reset_o(system_reset_o), .watchdog_restart_o(watchdog_restart_o));

// ==== tb/tb_ext_irq_and_reset_status.sv ====
module tb_ext_irq_and_reset_status;
  import irq_rst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0, wr = 1'b0, pa = 1'b0, pr = 1'b0, dbg = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [31:0] rbuf;
  logic [3:0] be = 4'hf;
  logic [7:0] src = 8'h00;
  logic [15:0] cpu_addr = 16'h0000;
  logic wait_o, pin, dbg_p, pull_en, pull_dn, irq_o, sys_rst, wd_rst;
  int err_count = 0;
  int checks_done = 0;
  int sidx[16] = '{0, 3, 1, 4, 5, 2, 6, 6, 5, 6, 8, 7, 7, 1, 3, 4};
  logic [15:0] sadr[16] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h1800, 16'hbfff, 16'h0, 16'h0880, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0};
  byte_reg_t scfg[16] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19,
    8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h08, 8'h19, 8'h18, 8'h1a,
    8'h1c};
  byte_reg_t sexp[16] = '{8'h40, 8'h10, 8'h20, 8'h10, 8'h04, 8'h10,
    8'h10, 8'h08, 8'h04, 8'h08, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02,
    8'h02};
  // The bus clock runs at 100 MHz.
  always #5 clk_i = ~clk_i;
  ext_irq_and_reset_status ext_irq_and_reset_status_inst (.clk_i(clk_i),
    .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .irq_pin_i(pin),
    .pull_enable_o(pull_en), .pull_down_select_o(pull_dn),
    .cpu_irq_o(irq_o), .reset_pin_n_i(!src[0]),
    .watchdog_timeout_i(src[1]), .bad_opcode_i(src[2]),
    .stop_exec_i(src[3]), .enter_background_instruction_exec_i(src[4]), .cpu_addr_i(cpu_addr),
    .cpu_access_i(src[6]), .clock_module_reset_i(src[5]),
    .low_volt_trip_i(src[7]), .stop_mode_i(1'b0),
    .debug_force_reset_i(dbg_p), .system_reset_o(sys_rst),
    .watchdog_restart_o(wd_rst));
  irq_pin_source irq_pin_source_inst (.clk_i(clk_i), .rst_i(rst_i),
    .assert_i(pa), .rising_i(pr), .dbg_cmd_i(dbg), .pin_o(pin),
    .dbg_pulse_o(dbg_p));
  // Prints the counts and the verdict, then ends the run.
  task test_done();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Compares one value and counts it.
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // One bus access, held until waitrequest is sampled low.
  task acc(input logic w, input logic [3:0] a, input byte_reg_t d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wait_o !== 1'b0 && n < 100);
    rbuf = rdata;
    if (n >= 100)
      chk("waitrequest", 32'h0, 32'h1);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  // Reads one register and compares its low byte and upper zeros.
  task rdc(input logic [3:0] a, input byte_reg_t e, input string n);
    acc(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rbuf);
  endtask
  // Raises one reset source for a cycle and lets the reset settle.
  task fire(input int i, input logic [15:0] a);
    cpu_addr <= a;
    if (i == 8)
      dbg <= 1'b1;
    else
      src[i] <= 1'b1;
    @(posedge clk_i);
    src <= 8'h00;
    dbg <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  // Main test sequence.
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(4'h4, 8'h82, "status");
    acc(1'b1, 4'h4, 8'hff);
    rdc(4'h4, 8'h82, "status kept");
    rdc(4'hc, 8'h00, "unmapped");
    acc(1'b1, 4'h0, 8'hd2);
    rdc(4'h0, 8'h12, "ctrl");
    be <= 4'he;
    acc(1'b1, 4'h0, 8'h00);
    be <= 4'hf;
    rdc(4'h0, 8'h12, "lane zero off");
    chk("pull", 32'h2, {30'h0, pull_en, pull_dn});
    pa <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(4'h0, 8'h1a, "falling");
    chk("irq", 32'h1, {31'h0, irq_o});
    acc(1'b1, 4'h0, 8'h12);
    rdc(4'h0, 8'h1a, "ack zero");
    acc(1'b1, 4'h0, 8'h16);
    rdc(4'h0, 8'h12, "ack");
    chk("irq off", 32'h0, {31'h0, irq_o});
    acc(1'b1, 4'h0, 8'h13);
    repeat (6) @(posedge clk_i);
    acc(1'b1, 4'h0, 8'h17);
    rdc(4'h0, 8'h1b, "level held");
    pa <= 1'b0;
    repeat (6) @(posedge clk_i);
    acc(1'b1, 4'h0, 8'h17);
    rdc(4'h0, 8'h13, "level clear");
    acc(1'b1, 4'h0, 8'h32);
    pr <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(4'h0, 8'h32, "rise no fall");
    chk("pull down", 32'h3, {30'h0, pull_en, pull_dn});
    pa <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(4'h0, 8'h3a, "rising");
    chk("irq rise", 32'h1, {31'h0, irq_o});
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 4'h8, scfg[i]);
      fire(sidx[i], sadr[i]);
      rdc(4'h4, sexp[i], "source");
    end
    rdc(4'h0, 8'h00, "ctrl cleared");
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(4'h4, 8'h82, "status again");
    fire(7, 16'h0000);
    rdc(4'h4, 8'h82, "low volt keeps");
    test_done();
  end
endmodule
